// [src/level_ctrl.sv]
// Automatic level control: AXI4-Lite registers, gain loop, gain outputs.
// Assumes samples and amplifier status arrive from logic on aclk.
`timescale 1ns/1ps
module level_ctrl
   import level_ctrl_pkg::*;
#(
   parameter logic [31:0] ATK_NORM_CYCLES = 32'(ATK_NORM_CYC),
   parameter logic [31:0] ATK_LIM_CYCLES  = 32'(ATK_LIM_CYC),
   parameter logic [31:0] DCY_NORM_CYCLES = 32'(DCY_NORM_CYC),
   parameter logic [31:0] DCY_LIM_CYCLES  = 32'(DCY_LIM_CYC),
   parameter logic [31:0] HOLD_CYCLES     = 32'(HOLD_BASE_CYC)
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output wire logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output wire logic        wready,
   output wire logic [1:0]  bresp,
   output wire logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output wire logic        arready,
   output wire logic [31:0] rdata,
   output wire logic [1:0]  rresp,
   output wire logic        rvalid,
   input  wire logic        rready,
   input  wire logic        sample_valid,
   input  wire logic [23:0] sample_left,
   input  wire logic [23:0] sample_right,
   input  wire logic        amp_on_left,
   input  wire logic        amp_on_right,
   output wire logic [5:0]  gain_left,
   output wire logic [5:0]  gain_right
);

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic        arready;
      logic        rvalid;
      logic [1:0]  bresp;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        aw_have;
      logic        w_have;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic [8:0]  r_limits;
      logic [8:0]  r_hold_tgt;
      logic [8:0]  r_mode_ad;
      logic [8:0]  r_gate;
      logic [17:0] r_manual;
      alc_state_e  st;
      logic [5:0]  gain;
      logic [5:0]  lim_cap;
      logic        lim_prev;
      logic        act_prev;
      logic [31:0] timer;
      logic [5:0]  gain_l;
      logic [5:0]  gain_r;
   } state_s;

   state_s s_ff;
   state_s nxt_s;

   peak_if pl ();
   peak_if pr ();

   assign pl.strobe = sample_valid;
   assign pl.smp    = sample_left;
   assign pr.strobe = sample_valid;
   assign pr.smp    = sample_right;

   peak_detector u_det_l (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .p       (pl)
   );

   peak_detector u_det_r (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .p       (pr)
   );

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic [31:0] scaled(input logic [31:0] base, input logic [3:0] code);
      // Codes past the table end keep the longest step time
      return base << ((code > MAX_SHIFT) ? MAX_SHIFT : code);
   endfunction

   function automatic logic [3:0] msb_pos(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) r = 4'(i);
      end
      return r;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic [1:0]         en;
      logic               act;
      logic               limiter;
      logic [15:0]        inst;
      logic [15:0]        avg;
      logic [15:0]        tgt;
      logic [15:0]        low;
      logic [5:0]         ceil;
      logic [5:0]         floor;
      logic [5:0]         g;
      logic               emerg;
      logic               over;
      logic               step_dn;
      logic               step_up;
      logic [31:0]        atk;
      logic [31:0]        dcy;
      logic [31:0]        hold;
      logic [3:0]         hcode;
      logic               boost;
      logic signed [10:0] lvl_q;
      logic signed [10:0] thr_q;
      logic               gate_on;

      nxt_s = s_ff;
      step_dn = 1'b0;
      step_up = 1'b0;

      // ======================================================
      // AXI4-Lite write channel
      if (awvalid && s_ff.awready) begin
         nxt_s.aw_have = 1'b1;
         nxt_s.aw_addr = awaddr;
      end
      if (wvalid && s_ff.wready) begin
         nxt_s.w_have = 1'b1;
         nxt_s.w_data = wdata;
         nxt_s.w_strb = wstrb;
      end
      if (s_ff.bvalid && bready) nxt_s.bvalid = 1'b0;
      if (s_ff.aw_have && s_ff.w_have && !s_ff.bvalid) begin
         nxt_s.aw_have = 1'b0;
         nxt_s.w_have  = 1'b0;
         nxt_s.bvalid  = 1'b1;
         nxt_s.bresp   = RESP_OKAY;
         case (s_ff.aw_addr[7:2])
            IDX_LIMITS:   nxt_s.r_limits   = 9'(merge(32'(s_ff.r_limits), s_ff.w_data, s_ff.w_strb));
            IDX_HOLD_TGT: nxt_s.r_hold_tgt = 9'(merge(32'(s_ff.r_hold_tgt), s_ff.w_data, s_ff.w_strb));
            IDX_MODE_AD:  nxt_s.r_mode_ad  = 9'(merge(32'(s_ff.r_mode_ad), s_ff.w_data, s_ff.w_strb));
            IDX_GATE:     nxt_s.r_gate     = 9'(merge(32'(s_ff.r_gate), s_ff.w_data, s_ff.w_strb));
            IDX_MANUAL:   nxt_s.r_manual   = 18'(merge(32'(s_ff.r_manual), s_ff.w_data, s_ff.w_strb));
            IDX_GAIN_RD, IDX_PEAK_RD, IDX_PP_RD: nxt_s.bresp = RESP_OKAY;
            default:      nxt_s.bresp = RESP_SLVERR;
         endcase
      end
      nxt_s.awready = !nxt_s.aw_have;
      nxt_s.wready  = !nxt_s.w_have;

      // ======================================================
      // AXI4-Lite read channel
      if (s_ff.rvalid && rready) nxt_s.rvalid = 1'b0;
      if (arvalid && s_ff.arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp  = RESP_OKAY;
         case (araddr[7:2])
            IDX_LIMITS:   nxt_s.rdata = 32'(s_ff.r_limits);
            IDX_HOLD_TGT: nxt_s.rdata = 32'(s_ff.r_hold_tgt);
            IDX_MODE_AD:  nxt_s.rdata = 32'(s_ff.r_mode_ad);
            IDX_GATE:     nxt_s.rdata = 32'(s_ff.r_gate);
            IDX_MANUAL:   nxt_s.rdata = 32'(s_ff.r_manual);
            IDX_GAIN_RD:  nxt_s.rdata = {11'h000, s_ff.st, 2'h0, s_ff.gain_r, 2'h0, s_ff.gain_l};
            IDX_PEAK_RD:  nxt_s.rdata = {pr.avg, pl.avg};
            IDX_PP_RD:    nxt_s.rdata = {pr.pp, pl.pp};
            default: begin
               nxt_s.rdata = 32'h0000_0000;
               nxt_s.rresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_s.arready = !nxt_s.rvalid;

      // ======================================================
      // Level decisions
      en      = s_ff.r_limits[EN_LSB +: 2];
      act     = (en != 2'b00);
      limiter = s_ff.r_mode_ad[MODE_BIT] && act;
      // Stereo loop: the louder enabled channel drives one shared gain
      inst = 16'h0000;
      avg  = 16'h0000;
      if (en[1]) begin
         inst = pl.mag;
         avg  = pl.avg;
      end
      if (en[0] && pr.mag > inst) inst = pr.mag;
      if (en[0] && pr.avg > avg) avg = pr.avg;
      tgt   = level_lin(5'(s_ff.r_hold_tgt[TGT_LSB +: 4]) + 5'h01);
      low   = level_lin(5'(s_ff.r_hold_tgt[TGT_LSB +: 4]));
      emerg = inst > EMERG_LEVEL;
      over  = inst > tgt;
      floor = {s_ff.r_limits[MIN_LSB +: 3], 3'b000};
      if (limiter) ceil = s_ff.lim_prev ? s_ff.lim_cap : s_ff.gain;
      else ceil = {s_ff.r_limits[MAX_LSB +: 3], 3'b111};
      atk = scaled(limiter ? ATK_LIM_CYCLES : ATK_NORM_CYCLES, s_ff.r_mode_ad[ATK_LSB +: 4]);
      dcy = scaled(limiter ? DCY_LIM_CYCLES : DCY_NORM_CYCLES, s_ff.r_mode_ad[DCY_LSB +: 4]);
      hcode = s_ff.r_hold_tgt[HOLD_LSB +: 4];
      hold  = (hcode == 4'h0) ? 32'h0000_0000 : scaled(HOLD_CYCLES, hcode);

      boost = (en[1] && s_ff.r_manual[BOOST_L]) || (en[0] && s_ff.r_manual[BOOST_R]);
      lvl_q = (11'(msb_pos(avg)) - 11'sd15) * 11'sd8 - (11'(s_ff.gain) - GAIN_Q0)
              - (boost ? BOOST_Q : 11'sd0);
      thr_q = GATE_Q0 - 11'(s_ff.r_gate[GTH_LSB +: 3]) * 11'sd8;
      gate_on = s_ff.r_gate[GEN_BIT] && act && !limiter && (lvl_q < thr_q);

      if (s_ff.timer != 32'h0000_0000) nxt_s.timer = s_ff.timer - 32'h0000_0001;

      // ======================================================
      // Gain loop
      case (s_ff.st)
         ST_IDLE: begin
            if (act) begin
               nxt_s.st    = ST_HOLD;
               nxt_s.timer = hold;
            end
         end
         ST_HOLD: begin
            if (emerg) begin
               nxt_s.st    = ST_EMERG;
               nxt_s.timer = ATK_LIM_CYCLES;
            end else if (over) begin
               nxt_s.st    = ST_ATTACK;
               nxt_s.timer = atk;
            end else if (avg >= tgt) begin
               nxt_s.timer = hold;
            end else if (s_ff.timer == 32'h0000_0000 && avg <= low) begin
               nxt_s.st    = ST_DECAY;
               nxt_s.timer = dcy;
            end
         end
         ST_ATTACK: begin
            if (emerg) begin
               nxt_s.st    = ST_EMERG;
               nxt_s.timer = ATK_LIM_CYCLES;
            end else if (avg <= low) begin
               nxt_s.st    = ST_HOLD;
               nxt_s.timer = hold;
            end else if (s_ff.timer == 32'h0000_0000) begin
               step_dn     = 1'b1;
               nxt_s.timer = atk;
            end
         end
         ST_DECAY: begin
            if (emerg) begin
               nxt_s.st    = ST_EMERG;
               nxt_s.timer = ATK_LIM_CYCLES;
            end else if (over) begin
               nxt_s.st    = ST_ATTACK;
               nxt_s.timer = atk;
            end else if (avg > low) begin
               nxt_s.st    = ST_HOLD;
               nxt_s.timer = hold;
            end else if (s_ff.timer == 32'h0000_0000) begin
               step_up     = !gate_on;
               nxt_s.timer = dcy;
            end
         end
         ST_EMERG: begin
            if (!emerg) begin
               nxt_s.st    = ST_ATTACK;
               nxt_s.timer = atk;
            end else if (s_ff.timer == 32'h0000_0000) begin
               step_dn     = 1'b1;
               nxt_s.timer = ATK_LIM_CYCLES;
            end
         end
         default: nxt_s.st = ST_IDLE;
      endcase
      if (!act) nxt_s.st = ST_IDLE;

      // Loop starts from the gain already applied, so no jump on enable
      g = s_ff.gain;
      if (act && !s_ff.act_prev) g = en[1] ? s_ff.gain_l : s_ff.gain_r;
      if (step_dn && g != 6'h00) g = g - 6'h01;
      if (step_up && g != 6'h3f) g = g + 6'h01;
      if (act) begin
         if (g > ceil) g = ceil;
         if (g < floor) g = floor;
      end
      nxt_s.gain     = g;
      nxt_s.act_prev = act;
      nxt_s.lim_prev = limiter;
      if (limiter && !s_ff.lim_prev) nxt_s.lim_cap = s_ff.gain;

      // ======================================================
      // Applied gains
      if (amp_on_left) begin
         nxt_s.gain_l = en[1] ? g : s_ff.r_manual[MAN_L_LSB +: 6];
      end
      if (amp_on_right) begin
         nxt_s.gain_r = en[0] ? g : s_ff.r_manual[MAN_R_LSB +: 6];
      end
      // Amplifier off: applied gain frozen at its last value
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff            <= '0;
         s_ff.r_limits   <= RST_LIMITS;
         s_ff.r_hold_tgt <= RST_HOLD_TGT;
         s_ff.r_mode_ad  <= RST_MODE_AD;
         s_ff.r_gate     <= RST_GATE;
         s_ff.r_manual   <= RST_MANUAL;
         s_ff.st         <= ST_IDLE;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   assign awready    = s_ff.awready;
   assign wready     = s_ff.wready;
   assign bvalid     = s_ff.bvalid;
   assign bresp      = s_ff.bresp;
   assign arready    = s_ff.arready;
   assign rvalid     = s_ff.rvalid;
   assign rdata      = s_ff.rdata;
   assign rresp      = s_ff.rresp;
   assign gain_left  = s_ff.gain_l;
   assign gain_right = s_ff.gain_r;
endmodule

// [src/level_ctrl_pkg.sv]
// Constants, register layout and level tables for the level control block.
// Assumes a 50 MHz clock and a decimated sample stream on the same clock.
//
// Notes on behaviour
// - Normal mode caps gain at max-gain field
// - Limiter caps gain at gain on entry
// - Loop gain never below min-gain field; manual gains not clamped
// - Enable field picks right, left or both
// - Target field sets level in 1.5dB steps
// - Above target, step gain down at attack pace
// - Stop reduction 1.5dB below target
// - Well below target, raise gain at decay pace
// - Increase only after below target for hold
// - Hold time doubles per code, capped
// - Attack step time doubles per code
// - Decay step time doubles, limiter faster
// - Mode bit plus enable selects limiter mode
// - Above 87.5% ramp down at fastest rate
// - Asserted noise gate freezes gain increases
// - Gate compares input-referred level to threshold
// - Noise gate only in active normal mode
// - Disabled amplifier keeps last applied gain
// - Instantaneous or averaged peak compared to target
// - Readback of gains and detector levels
// - Peak loads larger samples, otherwise decays
package level_ctrl_pkg;

   // ==========================================================
   // Register map
   localparam logic [5:0] IDX_LIMITS     = 6'h20;
   localparam logic [5:0] IDX_HOLD_TGT   = 6'h21;
   localparam logic [5:0] IDX_MODE_AD    = 6'h22;
   localparam logic [5:0] IDX_GATE       = 6'h23;
   localparam logic [5:0] IDX_MANUAL     = 6'h24;
   localparam logic [5:0] IDX_GAIN_RD    = 6'h25;
   localparam logic [5:0] IDX_PEAK_RD    = 6'h26;
   localparam logic [5:0] IDX_PP_RD      = 6'h27;

   localparam logic [8:0]  RST_LIMITS    = 9'h038;
   localparam logic [8:0]  RST_HOLD_TGT  = 9'h00b;
   localparam logic [8:0]  RST_MODE_AD   = 9'h032;
   localparam logic [8:0]  RST_GATE      = 9'h000;
   localparam logic [17:0] RST_MANUAL    = 18'h00000;

   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // ==========================================================
   // Field positions
   localparam int MIN_LSB   = 0;
   localparam int MAX_LSB   = 3;
   localparam int EN_LSB    = 7;
   localparam int TGT_LSB   = 0;
   localparam int HOLD_LSB  = 4;
   localparam int ATK_LSB   = 0;
   localparam int DCY_LSB   = 4;
   localparam int MODE_BIT  = 8;
   localparam int GTH_LSB   = 0;
   localparam int GEN_BIT   = 3;
   localparam int MAN_L_LSB = 0;
   localparam int MAN_R_LSB = 8;
   localparam int BOOST_L   = 16;
   localparam int BOOST_R   = 17;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS   = 20;
   localparam int ATK_NORM_NS     = 125000;
   localparam int ATK_LIM_NS      = 31000;
   localparam int DCY_NORM_NS     = 500000;
   localparam int DCY_LIM_NS      = 125000;
   localparam int HOLD_BASE_NS    = 1000000;
   localparam int ATK_NORM_CYC    = (ATK_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ATK_LIM_CYC     = (ATK_LIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DCY_NORM_CYC    = (DCY_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DCY_LIM_CYC     = (DCY_LIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_BASE_CYC   = (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] MAX_SHIFT = 4'ha;

   // ==========================================================
   // Levels, 16-bit magnitude, full scale 32767
   localparam logic [15:0] EMERG_LEVEL = 16'h7000;
   localparam int PEAK_DECAY_SHIFT = 10;
   localparam int AVG_SHIFT        = 6;
   localparam logic signed [10:0] GATE_Q0    = -11'sd52;
   localparam logic signed [10:0] BOOST_Q    = 11'sd27;
   localparam logic signed [10:0] GAIN_Q0    = 11'sd16;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_HOLD   = 5'b00010,
      ST_ATTACK = 5'b00100,
      ST_DECAY  = 5'b01000,
      ST_EMERG  = 5'b10000
   } alc_state_e;

   // Index i is -24dBFS + 1.5dB * i
   function automatic logic [15:0] level_lin(input logic [4:0] i);
      case (i)
         5'h00:   level_lin = 16'h0814;
         5'h01:   level_lin = 16'h0999;
         5'h02:   level_lin = 16'h0b69;
         5'h03:   level_lin = 16'h0d8f;
         5'h04:   level_lin = 16'h101d;
         5'h05:   level_lin = 16'h1327;
         5'h06:   level_lin = 16'h16c3;
         5'h07:   level_lin = 16'h1b0e;
         5'h08:   level_lin = 16'h2027;
         5'h09:   level_lin = 16'h2637;
         5'h0a:   level_lin = 16'h2d6b;
         5'h0b:   level_lin = 16'h35fa;
         5'h0c:   level_lin = 16'h4027;
         5'h0d:   level_lin = 16'h4c3f;
         5'h0e:   level_lin = 16'h5a9e;
         5'h0f:   level_lin = 16'h6bb3;
         default: level_lin = 16'h7fff;
      endcase
   endfunction

endpackage

// [src/peak_if.sv]
// Carries one channel's samples into a detector and its levels back out.
// Assumes all signals live on the block clock.
`timescale 1ns/1ps
interface peak_if;
   logic               strobe;
   logic signed [23:0] smp;
   logic [15:0]        mag;
   logic [15:0]        peak;
   logic [15:0]        avg;
   logic [15:0]        pp;

   modport det (input strobe, smp, output mag, peak, avg, pp);
   modport ctl (output strobe, smp, input mag, peak, avg, pp);
endinterface

// [src/peak_detector.sv]
// Per-channel peak, averaged peak and peak-to-peak detector.
// Assumes strobe marks one decimated sample on the block clock.
`timescale 1ns/1ps
module peak_detector
   import level_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   peak_if.det      p
);
   typedef struct packed {
      logic [15:0]        mag;
      logic [15:0]        peak;
      logic [15:0]        avg;
      logic signed [15:0] hi;
      logic signed [15:0] lo;
   } det_s;

   det_s s_ff;
   det_s nxt_s;

   // ==========================================================
   // Detector update
   always_comb begin
      logic signed [15:0] s16;
      logic [15:0]        d;
      s16 = p.smp[23:8];
      d = 16'h0000;
      nxt_s = s_ff;
      if (p.strobe) begin
         // Saturate so the most negative code has a magnitude
         if (s16 == -16'sd32768) nxt_s.mag = 16'h7fff;
         else if (s16 < 0) nxt_s.mag = 16'(-s16);
         else nxt_s.mag = 16'(s16);
         if (nxt_s.mag > s_ff.peak) begin
            nxt_s.peak = nxt_s.mag;
         end else if (s_ff.peak != 16'h0000) begin
            d = s_ff.peak >> PEAK_DECAY_SHIFT;
            nxt_s.peak = s_ff.peak - ((d == 16'h0000) ? 16'h0001 : d);
         end
         if (s_ff.avg < s_ff.peak) begin
            d = (s_ff.peak - s_ff.avg) >> AVG_SHIFT;
            nxt_s.avg = s_ff.avg + ((d == 16'h0000) ? 16'h0001 : d);
         end else if (s_ff.avg > s_ff.peak) begin
            d = (s_ff.avg - s_ff.peak) >> AVG_SHIFT;
            nxt_s.avg = s_ff.avg - ((d == 16'h0000) ? 16'h0001 : d);
         end
         if (s16 > s_ff.hi) nxt_s.hi = s16;
         else if (s_ff.hi > s_ff.lo) nxt_s.hi = s_ff.hi - 16'sd1;
         if (s16 < s_ff.lo) nxt_s.lo = s16;
         else if (s_ff.lo < s_ff.hi) nxt_s.lo = s_ff.lo + 16'sd1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) s_ff <= '0;
      else if (ce) s_ff <= nxt_s;
   end

   assign p.mag  = s_ff.mag;
   assign p.peak = s_ff.peak;
   assign p.avg  = s_ff.avg;
   assign p.pp   = (s_ff.hi > s_ff.lo) ? 16'(17'(s_ff.hi) - 17'(s_ff.lo)) : 16'h0000;
endmodule

// [dv/level_ctrl_checker.sv]
// Bus handshake and gain output properties of the level control block.
// Assumes binding to level_ctrl, seeing its ports only.
`timescale 1ns/1ps
module level_ctrl_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        amp_on_left,
   input wire logic        amp_on_right,
   input wire logic [5:0]  gain_left,
   input wire logic [5:0]  gain_right
);
   // ==========================================================
   // Properties
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (ce && bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_r_hold: assert property (ce && rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   a_ar_block: assert property (rvalid |-> !arready)
      else $error("read address taken while data waits");
   a_r_answer: assert property (ce && arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_b_answer: assert property (ce && awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid)
      else $error("write answer late");
   a_r_done: assert property (ce && rvalid && rready |=> !rvalid)
      else $error("read data repeated");
   a_left_frozen: assert property (ce && !amp_on_left |=> gain_left == $past(gain_left))
      else $error("left gain moved while amplifier off");
   a_right_frozen: assert property (ce && !amp_on_right |=> gain_right == $past(gain_right))
      else $error("right gain moved while amplifier off");
endmodule

// [dv/adc_feed.sv]
// Decimator model: alternating-sign samples at a set magnitude.
// Assumes the bench sets level; one sample every two clocks.
`timescale 1ns/1ps
module adc_feed (
   input wire logic  aclk,
   input wire logic  [15:0] level,
   output logic      sample_valid,
   output logic      [23:0] sample_left,
   output logic      [23:0] sample_right
);
   logic sgn = 1'b0;
   initial sample_valid = 1'b0;
   initial sample_left = 24'h000000;
   initial sample_right = 24'h000000;
   // ==========================================================
   // Sign flips so peak, not mean, carries the level
   always @(posedge aclk) begin
      sample_valid <= !sample_valid;
      if (!sample_valid) begin
         sgn <= !sgn;
         sample_left <= sgn ? -{level, 8'h00} : {level, 8'h00};
         sample_right <= sgn ? {level, 8'h00} : -{level, 8'h00};
      end
   end
endmodule

// [dv/level_ctrl_bench.sv]
// Self-checking bench: register access and gain loop scenarios.
// Assumes short timing parameters so each settle fits the run.
`timescale 1ns/1ps
module level_ctrl_bench
   import level_ctrl_pkg::*;
;
   logic        aclk = 0, aresetn = 0, ce = 1, amp_on_left = 1, amp_on_right = 1;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0]  wstrb = 4'hf;
   logic [15:0] level = 0;
   wire logic        awready, wready, bvalid, arready, rvalid, sample_valid;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [23:0] sample_left, sample_right;
   wire logic [5:0]  gain_left, gain_right;
   int          num_errors = 0, n_tests = 0, cyc_cnt = 0;
   always #10 aclk = ~aclk;
   level_ctrl #(.ATK_NORM_CYCLES(32'd4), .ATK_LIM_CYCLES(32'd2), .DCY_NORM_CYCLES(32'd8),
      .DCY_LIM_CYCLES(32'd4), .HOLD_CYCLES(32'd16)) i_level_ctrl (.aclk, .aresetn, .ce, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sample_valid, .sample_left,
      .sample_right, .amp_on_left, .amp_on_right, .gain_left, .gain_right);
   adc_feed i_adc_feed (.aclk, .level, .sample_valid, .sample_left, .sample_right);
   // ==========================================================
   // Tasks
   task automatic finish_test();
      if (num_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awready) ad = 1;
         if (wready) dd = 1;
         if (ad) awvalid <= 0;
         if (dd) wvalid <= 0;
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 0;
      chk(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input logic [31:0] m);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 0;
      chk(rdata & m, e);
      chk(32'(rresp), 32'(er));
   endtask
   // ==========================================================
   // Run, with a cycle ceiling against hangs
   always @(posedge aclk) begin
      cyc_cnt++;
      if (cyc_cnt == 60000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(8'h80, 32'h038, RESP_OKAY, 32'h1bf);
      rd(8'h84, 32'h00b, RESP_OKAY, 32'h0ff);
      rd(8'h88, 32'h032, RESP_OKAY, 32'h1ff);
      rd(8'h8c, 32'h000, RESP_OKAY, 32'h00f);
      rd(8'hfc, 32'h0, RESP_SLVERR, 32'hffffffff);
      wr(8'hfc, 32'h1ff, RESP_SLVERR);
      // Lane 1 only: target and hold keep their reset codes
      wstrb <= 4'h2;
      wr(8'h84, 32'h1ff, RESP_OKAY);
      wstrb <= 4'hf;
      rd(8'h84, 32'h10b, RESP_OKAY, 32'h1ff);
      wr(8'h90, 32'h152a, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(32'(gain_left), 32'h2a);
      amp_on_left <= 0;
      wr(8'h90, 32'h1010, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(32'(gain_left), 32'h2a);
      chk(32'(gain_right), 32'h10);
      amp_on_left <= 1;
      wr(8'h90, 32'h2020, RESP_OKAY);
      wr(8'h88, 32'h0, RESP_OKAY);
      level <= 16'h6000;
      wr(8'h80, 32'h1a2, RESP_OKAY);
      repeat (400) @(posedge aclk);
      chk(32'(gain_left < 6'h20), 32'h1);
      repeat (3000) @(posedge aclk);
      chk(32'(gain_left), 32'd16);
      chk(32'(gain_right), 32'd16);
      level <= 16'h0400;
      repeat (15000) @(posedge aclk);
      chk(32'(gain_left), 32'd39);
      rd(8'h94, 32'd39, RESP_OKAY, 32'h3f);
      // Slowest attack, so only the emergency path can pull gain down fast
      wr(8'h88, 32'h00a, RESP_OKAY);
      // Clock enable low freezes the loop even against an overload
      ce <= 0;
      amp_on_right <= 0;
      level <= 16'h7f00;
      repeat (100) @(posedge aclk);
      chk(32'(gain_left), 32'd39);
      ce <= 1;
      repeat (200) @(posedge aclk);
      chk(32'(gain_left), 32'd16);
      chk(32'(gain_right), 32'd39);
      amp_on_right <= 1;
      // Long hold lets the quiet level settle before any increase is due
      wr(8'h84, 32'h0ab, RESP_OKAY);
      wr(8'h8c, 32'h008, RESP_OKAY);
      level <= 16'h0100;
      repeat (21000) @(posedge aclk);
      chk(32'(gain_left), 32'd16);
      chk(32'(gain_right), 32'd16);
      wr(8'h84, 32'h00b, RESP_OKAY);
      wr(8'h88, 32'h100, RESP_OKAY);
      wr(8'h80, 32'h1ba, RESP_OKAY);
      level <= 16'h0400;
      repeat (3000) @(posedge aclk);
      chk(32'(gain_left), 32'd16);
      finish_test();
   end
endmodule
bind level_ctrl level_ctrl_checker i_level_ctrl_checker (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .amp_on_left,
   .amp_on_right, .gain_left, .gain_right);
